// File: rtl/smspi_pkg.sv
// shared constants and types of the switch monitor serial responder
package smspi_pkg;
    // frame layout, most significant bit first
    localparam int FRAME_BITS    = 32;
    localparam int DATA_BITS     = 24;
    localparam int ADDR_BITS     = 6;
    localparam int FLAG_COUNT    = 7;
    localparam int STAT_BITS     = 14;
    localparam int POS_WRITE     = 31;
    localparam int POS_ADDR_HI   = 30;
    localparam int POS_ADDR_LO   = 25;
    localparam int POS_DATA_HI   = 24;
    localparam int POS_DATA_LO   = 1;
    localparam int POS_PARITY    = 0;
    localparam logic [5:0] FRAME_COUNT   = 6'h20;
    localparam logic [5:0] ADDR_DONE_CNT = 6'h06;
    localparam logic [5:0] COUNT_MAX     = 6'h3f;
    // address map
    localparam logic [5:0] ADDR_INT_STAT   = 6'h02;
    localparam logic [5:0] ADDR_CFG_FIRST  = 6'h1a;
    localparam logic [5:0] ADDR_CFG_LAST   = 6'h32;
    localparam int         CFG_COUNT       = 25;
    localparam logic [5:0] ADDR_TEST_FIRST = 6'h3c;
    localparam logic [5:0] ADDR_TEST_LAST  = 6'h3f;
    // interrupt status bit positions
    localparam int IS_RESET = 0;
    localparam int IS_LEN   = 1;
    localparam int IS_PAR   = 2;
    localparam int IS_SWC   = 3;
    localparam int IS_TSD   = 4;
    localparam int IS_TW    = 5;
    localparam int IS_OV    = 6;
    localparam int IS_UV    = 7;
    localparam int IS_CSUM  = 8;
    localparam int IS_VSA   = 9;
    localparam int IS_VSB   = 10;
    localparam int IS_WET   = 11;
    localparam int IS_CONV  = 12;
    localparam int IS_CHK   = 13;
    // reset values
    localparam logic [13:0] INT_STAT_RESET = 14'h0001;
    localparam logic [23:0] CFG_RESET      = 24'h000000;
    localparam logic [23:0] TEST_RESET     = 24'h000000;
    typedef logic [23:0] smspi_word_type;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_FRAME  = 2'b01,
        ST_FINISH = 2'b10
    } smspi_state_type;
endpackage

// File: rtl/smspi_link_if.sv
// signals passed between the system-clock core and the serial-clock link
interface smspi_link_if;
    logic [31:0] frame_word;
    logic [5:0]  bit_count;
    logic        frame_toggle;
    logic [6:0]  flags;
    logic [5:0]  peek_addr;
    logic [23:0] peek_data;
    logic        peek_mapped;
    modport core (input frame_word, bit_count, frame_toggle, peek_addr,
                  output flags, peek_data, peek_mapped);
    modport link (output frame_word, bit_count, frame_toggle, peek_addr,
                  input flags, peek_data, peek_mapped);
endinterface

// File: rtl/smspi_sync.sv
// two flip-flop level synchroniser with synchronous reset
module smspi_sync #(
    parameter int         WIDTH       = 1,
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;

    // first stage feeds only the second
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            stage    <= RESET_VALUE[WIDTH-1:0];
            sync_out <= RESET_VALUE[WIDTH-1:0];
        end
        else
        begin
            stage    <= async_in;
            sync_out <= stage;
        end
    end
endmodule

// File: rtl/smspi_link.sv
// serial-clock side: input shifter, bit counter and output shifter
module smspi_link (
    input  wire logic sclk,
    input  wire logic srst,
    input  wire logic cs_n,
    input  wire logic si,
    output logic      so,
    output logic      so_oe_n,
    smspi_link_if.link lnk
);
    import smspi_pkg::*;

    logic [31:0]    rx_shift;
    logic [5:0]     rx_count;
    logic           rx_started;
    logic           toggle;
    logic [5:0]     tx_pos;
    smspi_word_type old_data;
    logic           old_mapped;
    logic           tx_bit;

    // the link clock stops between frames, so chip select ends the frame state
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
            rx_started <= 1'b0;
        else
            rx_started <= 1'b1;
    end

    // sample on falling edge, msb first; count saturates to flag long frames
    always_ff @(negedge sclk)
    begin
        rx_shift <= {rx_shift[30:0], si};
        if (!rx_started)
        begin
            rx_count <= 6'h01;
        end
        else if (rx_count != COUNT_MAX)
            rx_count <= rx_count + 6'h01;
        if (rx_started && rx_count == ADDR_DONE_CNT)
        begin
            old_data   <= lnk.peek_data;
            old_mapped <= lnk.peek_mapped;
        end
    end

    // the core's reset clears the toggle; the serial clock is idle meanwhile
    always_ff @(negedge sclk or posedge srst)
    begin
        if (srst)
            toggle <= 1'b0;
        else if (!rx_started)
            toggle <= ~toggle; // tells the core that this frame saw clocks
    end

    // address is complete once the seventh bit arrives
    assign lnk.peek_addr    = {rx_shift[4:0], si};
    assign lnk.frame_word   = rx_shift;
    assign lnk.bit_count    = rx_count;
    assign lnk.frame_toggle = toggle;

    // output bit: flags, then old content, then odd parity
    always_comb
    begin
        tx_bit = 1'b0;
        if (tx_pos < 6'h07)
            tx_bit = lnk.flags[3'(6'h06 - tx_pos)];
        else if (tx_pos < 6'h1f)
            tx_bit = old_mapped & old_data[5'(6'h1e - tx_pos)];
        else if (tx_pos == 6'h1f)
            tx_bit = old_mapped & ~^{lnk.flags, old_data};
    end

    // present the next bit on the rising edge; idle level is high
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            so     <= 1'b1;
            tx_pos <= 6'h00;
        end
        else
        begin
            so <= tx_bit;
            if (tx_pos != COUNT_MAX)
                tx_pos <= tx_pos + 6'h01;
        end
    end

    assign so_oe_n = cs_n;
endmodule

// File: rtl/smspi_top.sv
// switch monitor serial responder: frame checks, write commit, status flags
//
// Contract
// - a frame whose top bit is one is a write command.
// - six address bits follow the write bit and select the register.
// - writes to non-writable addresses are ignored, nothing changes.
// - frame bits 24 down to 1 carry the 24-bit write value.
// - bit 0 is parity on both input and output frames.
// - output carries status flags first, then the previous register content.
// - previous content is captured once the address bits are complete.
// - commit only at frame end, valid address, no length or parity error.
// - test-mode registers are never written but still return their content.
// - an unmapped address returns zeros for content and parity; the status flags are still sent.
// - status flags are copies of interrupt status bits, no own storage.
// - reading interrupt status clears it when chip select rises.
// - reset-event flag is set after any reset.
// - only exactly 32 bits are accepted; any other clocked length gives length error and interrupt.
// - chip select toggling with no clock edges raises no length error.
// - odd parity over the frame; even count discards, flags, interrupts.
// - switch-change flag mirrors the switch-change status bit.
// - supply flag is the or of both supply crossing bits.
// - thermal flag is the or of warning and shutdown bits.
// - other-event flag ors the six remaining event bits.
// - serial input is sampled on each falling clock edge.
// - each output bit is presented on a rising clock edge.
// - frames travel most significant bit first.
module smspi_top #(
    parameter smspi_pkg::smspi_word_type TEST_VALUE = smspi_pkg::TEST_RESET
) (
    input  wire logic                          clock,
    input  wire logic                          srst,
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    input  wire logic                          si,
    output logic                               so,
    output logic                               so_oe_n,
    input  wire logic                          soft_reset_event,
    input  wire logic                          switch_change,
    input  wire logic                          thermal_shutdown,
    input  wire logic                          thermal_warning,
    input  wire logic                          over_voltage,
    input  wire logic                          under_voltage,
    input  wire logic                          checksum_done,
    input  wire logic                          supply_cross_a,
    input  wire logic                          supply_cross_b,
    input  wire logic                          wetting_diagnostic_fault,
    input  wire logic                          converter_diagnostic_fault,
    input  wire logic                          check_failure,
    output logic                               int_n,
    output logic [smspi_pkg::STAT_BITS-1:0]    int_stat_view,
    output logic                               parity_error,
    output logic                               length_error,
    output logic                               write_strobe,
    output logic [smspi_pkg::ADDR_BITS-1:0]    write_addr,
    output smspi_pkg::smspi_word_type          write_data,
    output logic [smspi_pkg::CFG_COUNT*24-1:0] config_flat
);
    import smspi_pkg::*;

    smspi_link_if lnk ();

    smspi_state_type state;
    logic [1:0]      sync_out;
    logic            cs_s;
    logic            toggle_s;
    logic            toggle_seen;
    logic [13:0]     int_stat;
    logic [13:0]     stat_snap;
    logic [13:0]     set_mask;
    logic            do_clear;
    smspi_word_type  cfg [CFG_COUNT];
    logic            is_write;
    logic [5:0]      frame_addr;
    smspi_word_type  frame_data;
    logic            edges_seen;
    logic            length_ok;
    logic            parity_ok;
    logic            frame_valid;
    logic            cfg_hit;
    logic [4:0]      cfg_index;
    logic            commit;
    logic            int_read;
    logic            length_fail;
    logic            parity_fail;
    logic [4:0]      peek_index;
    logic            reset_event_flag;
    logic            length_flag;
    logic            parity_flag;
    logic            switch_change_flag;
    logic            supply_threshold_flag;
    logic            thermal_flag;
    logic            other_event_flag;
    logic            link_srst;

    // serial-clock logic lives in its own domain
    smspi_link u_link (
        .sclk    (sclk),
        .srst    (link_srst),
        .cs_n    (cs_n),
        .si      (si),
        .so      (so),
        .so_oe_n (so_oe_n),
        .lnk     (lnk.link)
    );

    // chip select and the frame toggle enter the system clock domain
    smspi_sync #(
        .WIDTH       (2),
        .RESET_VALUE (8'h01)
    ) u_sync (
        .clock    (clock),
        .srst     (srst),
        .async_in ({lnk.frame_toggle, cs_n}),
        .sync_out (sync_out)
    );

    assign cs_s     = sync_out[0];
    assign toggle_s = sync_out[1];

    // reset copy for the link toggle, launched from a flop
    always_ff @(posedge clock)
    begin
        link_srst <= srst;
    end

    // frame tracking: idle, inside a frame, one cycle to finish it
    always_ff @(posedge clock)
    begin
        if (srst)
            state <= ST_IDLE;
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (!cs_s)
                        state <= ST_FRAME;
                end
                ST_FRAME:
                begin
                    if (cs_s)
                        state <= ST_FINISH;
                end
                ST_FINISH:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // remember the toggle seen at each frame end to spot clockless frames
    always_ff @(posedge clock)
    begin
        if (srst)
            toggle_seen <= 1'b0;
        else if (state == ST_FINISH)
            toggle_seen <= toggle_s;
    end

    // frame fields; the link holds them steady once chip select is high
    assign is_write   = lnk.frame_word[POS_WRITE];
    assign frame_addr = lnk.frame_word[POS_ADDR_HI:POS_ADDR_LO];
    assign frame_data = lnk.frame_word[POS_DATA_HI:POS_DATA_LO];

    // checks on the finished frame
    assign edges_seen = toggle_s != toggle_seen;
    assign length_ok  = lnk.bit_count == FRAME_COUNT;
    assign parity_ok  = ^lnk.frame_word;

    // parity is judged only on frames of the right length
    assign length_fail = (state == ST_FINISH) && edges_seen && !length_ok;
    assign parity_fail = (state == ST_FINISH) && edges_seen && length_ok
                       && !parity_ok;
    assign frame_valid = (state == ST_FINISH) && edges_seen && length_ok && parity_ok;

    // only the configuration block is writable; test registers never are
    assign cfg_hit   = frame_addr >= ADDR_CFG_FIRST && frame_addr <= ADDR_CFG_LAST;
    assign cfg_index = 5'(frame_addr - ADDR_CFG_FIRST);

    // outcomes of a valid frame
    assign commit    = frame_valid && is_write && cfg_hit;
    assign int_read  = frame_valid && !is_write && frame_addr == ADDR_INT_STAT;
    assign do_clear  = int_read;

    // events that set interrupt status bits this cycle
    always_comb
    begin
        set_mask           = 14'h0000;
        set_mask[IS_RESET] = soft_reset_event;
        set_mask[IS_LEN]   = length_fail;
        set_mask[IS_PAR]   = parity_fail;
        // event inputs are one-cycle pulses
        set_mask[IS_SWC]   = switch_change;
        set_mask[IS_TSD]   = thermal_shutdown;
        set_mask[IS_TW]    = thermal_warning;
        set_mask[IS_OV]    = over_voltage;
        set_mask[IS_UV]    = under_voltage;
        set_mask[IS_CSUM]  = checksum_done;
        set_mask[IS_VSA]   = supply_cross_a;
        set_mask[IS_VSB]   = supply_cross_b;
        set_mask[IS_WET]   = wetting_diagnostic_fault;
        set_mask[IS_CONV]  = converter_diagnostic_fault;
        set_mask[IS_CHK]   = check_failure;
    end

    // sticky status; a set in the clearing cycle survives the clear
    always_ff @(posedge clock)
    begin
        if (srst)
            int_stat <= INT_STAT_RESET;
        else if (do_clear)
            int_stat <= set_mask;
        else
            int_stat <= int_stat | set_mask;
    end

    // frozen copy while a frame runs so the link sees a stable picture
    always_ff @(posedge clock)
    begin
        if (srst)
            stat_snap <= INT_STAT_RESET;
        else if (state == ST_IDLE && cs_s)
            stat_snap <= int_stat;
    end

    // flags are pure functions of the status copy
    assign reset_event_flag      = stat_snap[IS_RESET];
    assign length_flag           = stat_snap[IS_LEN];
    assign parity_flag           = stat_snap[IS_PAR];

    // event flags fold status bits
    assign switch_change_flag    = stat_snap[IS_SWC];
    assign supply_threshold_flag = stat_snap[IS_VSA] | stat_snap[IS_VSB];
    assign thermal_flag          = stat_snap[IS_TW] | stat_snap[IS_TSD];
    assign other_event_flag      = stat_snap[IS_OV] | stat_snap[IS_UV]
                                 | stat_snap[IS_CSUM] | stat_snap[IS_WET]
                                 | stat_snap[IS_CONV] | stat_snap[IS_CHK];

    // fixed flag order, first one leaves on the top bit
    assign lnk.flags = {reset_event_flag, length_flag, parity_flag,
                        switch_change_flag, supply_threshold_flag,
                        thermal_flag, other_event_flag};

    // configuration storage, written only at frame end
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            for (int i = 0; i < CFG_COUNT; i++)
                cfg[i] <= CFG_RESET;
        end
        else if (commit)
            cfg[cfg_index] <= frame_data;
    end

    // old content lookup for the link; cfg only changes between frames
    assign peek_index = 5'(lnk.peek_addr - ADDR_CFG_FIRST);

    // status reads show the frozen copy
    always_comb
    begin
        lnk.peek_data   = 24'h000000;
        lnk.peek_mapped = 1'b0;
        if (lnk.peek_addr == ADDR_INT_STAT)
        begin
            lnk.peek_data   = {10'h000, stat_snap};
            lnk.peek_mapped = 1'b1;
        end
        else if (lnk.peek_addr >= ADDR_CFG_FIRST && lnk.peek_addr <= ADDR_CFG_LAST)
        begin
            lnk.peek_data   = cfg[peek_index];
            lnk.peek_mapped = 1'b1;
        end
        else if (lnk.peek_addr >= ADDR_TEST_FIRST && lnk.peek_addr <= ADDR_TEST_LAST)
        begin
            lnk.peek_data   = TEST_VALUE;
            lnk.peek_mapped = 1'b1;
        end
    end

    // interrupt line low while any status bit is pending
    always_ff @(posedge clock)
    begin
        if (srst)
            int_n <= 1'b0;
        else
            int_n <= ~|int_stat;
    end

    // registered status view and error indicators
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            int_stat_view <= INT_STAT_RESET;
            parity_error  <= 1'b0;
            length_error  <= 1'b0;
        end
        else
        begin
            int_stat_view <= int_stat;
            parity_error  <= int_stat[IS_PAR];
            length_error  <= int_stat[IS_LEN];
        end
    end

    // one-cycle notice of each committed write
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            write_strobe <= 1'b0;
            write_addr   <= 6'h00;
            write_data   <= 24'h000000;
        end
        else
        begin
            write_strobe <= commit;
            if (commit)
            begin
                write_addr <= frame_addr;
                write_data <= frame_data;
            end
        end
    end

    // configuration words flattened for the rest of the chip
    genvar g;
    generate
        for (g = 0; g < CFG_COUNT; g++)
        begin : g_cfg
            always_ff @(posedge clock)
            begin
                if (srst)
                    config_flat[g*24 +: 24] <= CFG_RESET;
                else
                    config_flat[g*24 +: 24] <= cfg[g];
            end
        end
    endgenerate
endmodule

// File: bench/smspi_host.sv
// host controller model that frames words onto the serial pins
module smspi_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle pins: clock low, chip select high
    initial
    begin
        sclk = 1'b0;
        si   = 1'b0;
        #1 cs_n = 1'b1;                  // a real rising edge clears the output stage
    end

    // one frame of nbits clocks; 12 ns clock only while selected
    task automatic xfer(input logic [31:0] word, input int nbits, output logic [31:0] got);
        got  = 32'h0;
        cs_n = 1'b0;
        si   = word[31];                 // write bit leads, msb first
        #300;                            // status snapshot settles before the first edge
        for (int k = 0; k < nbits; k++)
        begin
            sclk = 1'b1;                 // responder launches its bit here
            #6;
            sclk = 1'b0;                 // both sides sample here
            got  = {got[30:0], so};
            #3;                          // data moves clear of the sampling edge
            si   = (k < 31) ? word[30-k] : ~si;  // address, data, parity
            #3;
        end
        cs_n = 1'b1;
        si   = ~si;                      // released line must not keep a valid look
        #600;                            // gap longer than five system clocks
    endtask
endmodule

// File: bench/smspi_top_sva.sv
// concurrent checks on the ports of the serial responder
module smspi_top_sva
    import smspi_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   srst,
    input wire logic                   cs_n,
    input wire logic                   so,
    input wire logic                   so_oe_n,
    input wire logic                   soft_reset_event,
    input wire logic                   switch_change,
    input wire logic                   thermal_warning,
    input wire logic                   supply_cross_a,
    input wire logic                   check_failure,
    input wire logic [STAT_BITS-1:0]   int_stat_view,
    input wire logic                   parity_error,
    input wire logic                   length_error,
    input wire logic                   write_strobe,
    input wire logic [ADDR_BITS-1:0]   write_addr,
    input wire smspi_word_type         write_data,
    input wire logic [CFG_COUNT*24-1:0] config_flat
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_so_released: assert property (cs_n |-> so && so_oe_n)
        else $error("serial output not released while deselected");
    a_parity_copy: assert property (parity_error == int_stat_view[IS_PAR])
        else $error("parity flag differs from status");
    a_length_copy: assert property (length_error == int_stat_view[IS_LEN])
        else $error("length flag differs from status");
    a_reset_sets: assert property (soft_reset_event |-> ##[1:3] int_stat_view[IS_RESET])
        else $error("reset event not recorded");
    a_switch_sets: assert property (switch_change |-> ##[1:3] int_stat_view[IS_SWC])
        else $error("switch change not recorded");
    a_supply_sets: assert property (supply_cross_a |-> ##[1:3] int_stat_view[IS_VSA])
        else $error("supply crossing not recorded");
    a_thermal_sets: assert property (thermal_warning |-> ##[1:3] int_stat_view[IS_TW])
        else $error("thermal warning not recorded");
    a_other_sets: assert property (check_failure |-> ##[1:3] int_stat_view[IS_CHK])
        else $error("check failure not recorded");
    a_strobe_pulse: assert property (write_strobe |=> !write_strobe)
        else $error("write strobe longer than one cycle");
    a_commit_after_cs: assert property (write_strobe |-> cs_n && $past(cs_n, 2))
        else $error("commit before the frame ended");
    a_commit_addr: assert property (write_strobe |->
        write_addr >= ADDR_CFG_FIRST && write_addr <= ADDR_CFG_LAST)
        else $error("commit to a non-writable address");
    a_config_lands: assert property (write_strobe |=>
        config_flat[($past(write_addr) - ADDR_CFG_FIRST) * 24 +: 24] == $past(write_data))
        else $error("committed word not stored");

    // main scenarios reached
    c_commit: cover property (write_strobe);
    c_length: cover property ($rose(length_error));
    c_parity: cover property ($rose(parity_error));
endmodule

bind smspi_top smspi_top_sva i_smspi_top_sva (.clock, .srst, .cs_n, .so, .so_oe_n,
    .soft_reset_event, .switch_change, .thermal_warning, .supply_cross_a, .check_failure,
    .int_stat_view, .parity_error, .length_error, .write_strobe, .write_addr, .write_data,
    .config_flat);

// File: bench/smspi_top_test.sv
// self-checking bench for the serial responder
module smspi_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import smspi_pkg::*;

    typedef struct packed {logic [5:0] a; logic [23:0] d; logic [23:0] old; logic commit;} smspi_row_type;
    localparam smspi_word_type TVAL = 24'h00c3a5;
    logic                    clock = 1'b0;
    logic                    srst  = 1'b1;
    logic [13:0]             ev    = 14'h0000;
    logic                    sclk, cs_n, si, so, so_oe_n, int_n;
    logic                    parity_error, length_error, write_strobe;
    logic [STAT_BITS-1:0]    int_stat_view;
    logic [ADDR_BITS-1:0]    write_addr;
    smspi_word_type          write_data;
    logic [CFG_COUNT*24-1:0] config_flat;
    logic [31:0]             got;
    int                      bad_count = 0, checks_done = 0, strobes = 0, cycles = 0, n0;
    int                      fpos [14] = '{31, 30, 29, 28, 26, 26, 25, 25, 25, 27, 27, 25, 25, 25};
    int                      ids [12] = '{0, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13};
    smspi_row_type           rows [7] = '{
        '{6'h1a, 24'habcdef, 24'h000000, 1'b1}, '{6'h1a, 24'h123456, 24'habcdef, 1'b1},
        '{6'h32, 24'hffffff, 24'h000000, 1'b1}, '{6'h3c, 24'h5a5a5a, TVAL, 1'b0},
        '{6'h3c, 24'h000001, TVAL, 1'b0}, '{6'h02, 24'h000fff, 24'h000000, 1'b0},
        '{6'h05, 24'h777777, 24'h000000, 1'b0}};

    // 100 ns system clock; strobes counted, hang cut short
    always #50 clock = ~clock;
    always @(posedge clock)
    begin
        strobes += write_strobe;
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            end_sim();
        end
    end

    smspi_host i_smspi_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
    smspi_top #(.TEST_VALUE(TVAL)) i_smspi_top (.clock(clock), .srst(srst), .sclk(sclk),
        .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n), .soft_reset_event(ev[IS_RESET]),
        .switch_change(ev[IS_SWC]), .thermal_shutdown(ev[IS_TSD]), .thermal_warning(ev[IS_TW]),
        .over_voltage(ev[IS_OV]), .under_voltage(ev[IS_UV]), .checksum_done(ev[IS_CSUM]),
        .supply_cross_a(ev[IS_VSA]), .supply_cross_b(ev[IS_VSB]),
        .wetting_diagnostic_fault(ev[IS_WET]), .converter_diagnostic_fault(ev[IS_CONV]),
        .check_failure(ev[IS_CHK]), .int_n(int_n), .int_stat_view(int_stat_view),
        .parity_error(parity_error), .length_error(length_error), .write_strobe(write_strobe),
        .write_addr(write_addr), .write_data(write_data), .config_flat(config_flat));

    // command word with odd parity over all 32 bits
    function automatic logic [31:0] cmd(input logic w, input logic [5:0] a, input logic [23:0] d);
        return {w, a, d, ~^{w, a, d}};
    endfunction

    // answer word: flags, old content, odd parity over 31..1
    function automatic logic [31:0] resp(input logic [6:0] fl, input logic [23:0] d);
        return {fl, d, ~^{fl, d}};
    endfunction

    task automatic check(input logic [599:0] seen, input logic [599:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("BAD at %0t seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic frame(input logic [31:0] w, input int n, input logic [31:0] want);
        i_smspi_host.xfer(w, n, got);
        check(got, want);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence: status read, table of writes, then the awkward frames
    initial
    begin
        repeat (12) @(negedge clock);
        srst = 1'b0;
        repeat (4) @(negedge clock);
        check({int_n, int_stat_view}, 15'h0001);
        frame(cmd(1'b0, ADDR_INT_STAT, 24'h0), 32, resp(7'h40, 24'h000001));
        check({int_n, int_stat_view}, 15'h4000);
        foreach (rows[j])
        begin
            n0 = strobes;
            frame(cmd(1'b1, rows[j].a, rows[j].d), 32,
                (rows[j].a == 6'h05) ? 32'h0 : resp(7'h0, rows[j].old));
            check(strobes - n0, rows[j].commit);
            if (rows[j].commit)
                check({write_addr, write_data}, {rows[j].a, rows[j].d});
        end
        check({config_flat[599:576], config_flat[23:0]}, 48'hffffff123456);
        // short frame is discarded and flagged
        frame(cmd(1'b1, 6'h1b, 24'h00aaaa), 31, 32'h0);
        check({length_error, int_n, config_flat[47:24]}, 26'h2000000);
        frame(cmd(1'b0, ADDR_INT_STAT, 24'h0), 32, resp(7'h20, 24'h000002));
        // chip select toggled without any clock edge
        frame(32'h0, 0, 32'h0);
        check({length_error, int_n}, 2'b01);
        // one flipped parity bit
        n0 = strobes;
        frame(cmd(1'b1, 6'h1b, 24'h0000aa) ^ 32'h1, 32, resp(7'h0, 24'h0));
        check({parity_error, int_n, config_flat[47:24]}, 26'h2000000);
        check(strobes - n0, 0);
        frame(cmd(1'b0, ADDR_INT_STAT, 24'h0), 32, resp(7'h10, 24'h000004));
        frame(cmd(1'b1, 6'h1b, 24'h005555), 33, 32'h2);
        frame(cmd(1'b0, ADDR_INT_STAT, 24'h0), 32, resp(7'h20, 24'h000002));
        // each event source, seen in the flags and then cleared by a read
        foreach (ids[j])
        begin
            @(negedge clock) ev[ids[j]] = 1'b1;
            @(negedge clock) ev = 14'h0000;
            repeat (4) @(negedge clock);
            check(int_n, 1'b0);
            frame(cmd(1'b0, ADDR_INT_STAT, 24'h0), 32,
                resp(7'h01 << (fpos[ids[j]] - 25), 24'h1 << ids[j]));
            check({int_n, int_stat_view}, 15'h4000);
        end
        end_sim();
    end
endmodule
